//--- hw/biowd_decoder.v
// I/O and memory-mapped I/O forwarding decoder of the bus bridge.
`timescale 1ns/1ps
`include "biowd_map.vh"
module biowd_decoder (
  input wire clk_i,
  input wire arst_n_i,
  // Configuration write/read port
  input wire cfg_wr_i,
  input wire cfg_rd_i,
  input wire [7:0] cfg_addr_i,
  input wire [1:0] cfg_be_i,
  input wire [15:0] cfg_wdata_i,
  output reg [15:0] cfg_rdata_o,
  output reg cfg_rvalid_o,
  // Command and bridge control bits
  input wire io_en_i,
  input wire mem_en_i,
  input wire master_en_i,
  input wire isa_en_i,
  // Claims from decoders outside this block
  input wire sec_mem_other_claim_i,
  // Primary-side address phase
  input wire pri_valid_i,
  input wire [3:0] pri_cmd_i,
  input wire [31:0] pri_addr_i,
  // Secondary-side address phase
  input wire sec_valid_i,
  input wire [3:0] sec_cmd_i,
  input wire [31:0] sec_addr_i,
  // Decisions
  output reg pri_fwd_down_o,
  output reg sec_fwd_up_o,
  output reg fwd_prefetch_o,
  output reg fwd_single_o,
  output reg dec_valid_o
);
  // ----------------------------------------------------------------------
  // Window registers
  // ----------------------------------------------------------------------
  reg [3:0] io_base_mid_ff;
  reg [3:0] io_limit_mid_ff;
  reg [15:0] io_base_hi_ff;
  reg [15:0] io_limit_hi_ff;
  reg [11:0] mmio_base_ff;
  reg [11:0] mmio_limit_ff;

  // Byte-lane write of the window fields
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      io_base_mid_ff <= `BIOWD_IO_BASE_MID_RST;
      io_base_hi_ff <= `BIOWD_IO_BASE_HI_RST;
      io_limit_mid_ff <= `BIOWD_IO_LIMIT_MID_RST;
      io_limit_hi_ff <= `BIOWD_IO_LIMIT_HI_RST;
      mmio_base_ff <= `BIOWD_MMIO_BASE_RST;
      mmio_limit_ff <= `BIOWD_MMIO_LIMIT_RST;
    end else if (cfg_wr_i) begin
      // The 1Ch/1Dh pair shares one halfword; lane 0 base, lane 1 limit
      if (cfg_addr_i == `BIOWD_OFS_IO_BASE_LO) begin
        if (cfg_be_i[0]) begin
          io_base_mid_ff <= cfg_wdata_i[7:4];
        end
        if (cfg_be_i[1]) begin
          io_limit_mid_ff <= cfg_wdata_i[15:12];
        end
      end else if (cfg_addr_i == `BIOWD_OFS_IO_LIMIT_LO) begin
        if (cfg_be_i[0]) begin
          io_limit_mid_ff <= cfg_wdata_i[7:4];
        end
      end else if (cfg_addr_i == `BIOWD_OFS_MMIO_BASE) begin
        if (cfg_be_i[0]) begin
          mmio_base_ff[3:0] <= cfg_wdata_i[7:4];
        end
        if (cfg_be_i[1]) begin
          mmio_base_ff[11:4] <= cfg_wdata_i[15:8];
        end
      end else if (cfg_addr_i == `BIOWD_OFS_MMIO_LIMIT) begin
        if (cfg_be_i[0]) begin
          mmio_limit_ff[3:0] <= cfg_wdata_i[7:4];
        end
        if (cfg_be_i[1]) begin
          mmio_limit_ff[11:4] <= cfg_wdata_i[15:8];
        end
      end else if (cfg_addr_i == `BIOWD_OFS_IO_BASE_HI) begin
        if (cfg_be_i[0]) begin
          io_base_hi_ff[7:0] <= cfg_wdata_i[7:0];
        end
        if (cfg_be_i[1]) begin
          io_base_hi_ff[15:8] <= cfg_wdata_i[15:8];
        end
      end else if (cfg_addr_i == `BIOWD_OFS_IO_LIMIT_HI) begin
        if (cfg_be_i[0]) begin
          io_limit_hi_ff[7:0] <= cfg_wdata_i[7:0];
        end
        if (cfg_be_i[1]) begin
          io_limit_hi_ff[15:8] <= cfg_wdata_i[15:8];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------------
  reg [15:0] nxt_rdata;

  // Unmapped offsets read as zero
  always @* begin
    nxt_rdata = 16'h0000;
    if (cfg_addr_i == `BIOWD_OFS_IO_BASE_LO) begin
      nxt_rdata = {io_limit_mid_ff, `BIOWD_IO_CAP_32,
                   io_base_mid_ff, `BIOWD_IO_CAP_32};
    end else if (cfg_addr_i == `BIOWD_OFS_IO_LIMIT_LO) begin
      nxt_rdata = {8'h00, io_limit_mid_ff, `BIOWD_IO_CAP_32};
    end else if (cfg_addr_i == `BIOWD_OFS_MMIO_BASE) begin
      nxt_rdata = {mmio_base_ff, `BIOWD_MMIO_LOW_ZERO};
    end else if (cfg_addr_i == `BIOWD_OFS_MMIO_LIMIT) begin
      nxt_rdata = {mmio_limit_ff, `BIOWD_MMIO_LOW_ZERO};
    end else if (cfg_addr_i == `BIOWD_OFS_IO_BASE_HI) begin
      nxt_rdata = io_base_hi_ff;
    end else if (cfg_addr_i == `BIOWD_OFS_IO_LIMIT_HI) begin
      nxt_rdata = io_limit_hi_ff;
    end
  end

  // Read data lands one cycle after the strobe
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_rdata_o <= 16'h0000;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_rd_i;
      if (cfg_rd_i) begin
        cfg_rdata_o <= nxt_rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Expanded window bounds
  // ----------------------------------------------------------------------
  wire [31:0] io_base_full;
  wire [31:0] io_limit_full;
  wire [31:0] mmio_base_full;
  wire [31:0] mmio_limit_full;

  // Full 32-bit I/O decode, 4KB aligned
  assign io_base_full = {io_base_hi_ff, io_base_mid_ff,
                         `BIOWD_IO_BASE_FILL};
  assign io_limit_full = {io_limit_hi_ff, io_limit_mid_ff,
                          `BIOWD_IO_LIMIT_FILL};
  // 1MB granular memory-mapped window
  assign mmio_base_full = {mmio_base_ff, `BIOWD_MMIO_BASE_FILL};
  assign mmio_limit_full = {mmio_limit_ff, `BIOWD_MMIO_LIMIT_FILL};

  // ----------------------------------------------------------------------
  // Window hits, one comparator per side and window
  // ----------------------------------------------------------------------
  wire pri_io_hit;
  wire sec_io_hit;
  wire pri_mm_hit;
  wire sec_mm_hit;

  // Base above limit gives no hit on either window
  biowd_range_cmp #(.W(32)) u_pri_io (
    .addr_i(pri_addr_i),
    .base_i(io_base_full),
    .limit_i(io_limit_full),
    .hit_o(pri_io_hit)
  );
  biowd_range_cmp #(.W(32)) u_sec_io (
    .addr_i(sec_addr_i),
    .base_i(io_base_full),
    .limit_i(io_limit_full),
    .hit_o(sec_io_hit)
  );
  biowd_range_cmp #(.W(32)) u_pri_mm (
    .addr_i(pri_addr_i),
    .base_i(mmio_base_full),
    .limit_i(mmio_limit_full),
    .hit_o(pri_mm_hit)
  );
  biowd_range_cmp #(.W(32)) u_sec_mm (
    .addr_i(sec_addr_i),
    .base_i(mmio_base_full),
    .limit_i(mmio_limit_full),
    .hit_o(sec_mm_hit)
  );

  // ----------------------------------------------------------------------
  // Command classes
  // ----------------------------------------------------------------------
  wire pri_is_io;
  wire sec_is_io;
  wire pri_is_mem;
  wire sec_is_mem;

  assign pri_is_io = (pri_cmd_i == `BIOWD_CMD_IO_RD) ||
                     (pri_cmd_i == `BIOWD_CMD_IO_WR);
  assign sec_is_io = (sec_cmd_i == `BIOWD_CMD_IO_RD) ||
                     (sec_cmd_i == `BIOWD_CMD_IO_WR);
  assign pri_is_mem = (pri_cmd_i == `BIOWD_CMD_MEM_RD) ||
                      (pri_cmd_i == `BIOWD_CMD_MEM_WR) ||
                      (pri_cmd_i == `BIOWD_CMD_MEM_RD_MUL) ||
                      (pri_cmd_i == `BIOWD_CMD_MEM_RD_LINE) ||
                      (pri_cmd_i == `BIOWD_CMD_MEM_WR_INV);
  assign sec_is_mem = (sec_cmd_i == `BIOWD_CMD_MEM_RD) ||
                      (sec_cmd_i == `BIOWD_CMD_MEM_WR) ||
                      (sec_cmd_i == `BIOWD_CMD_MEM_RD_MUL) ||
                      (sec_cmd_i == `BIOWD_CMD_MEM_RD_LINE) ||
                      (sec_cmd_i == `BIOWD_CMD_MEM_WR_INV);

  // ----------------------------------------------------------------------
  // ISA alias detection
  // ----------------------------------------------------------------------
  wire pri_isa_alias;
  wire sec_isa_alias;

  // Low 64KB only, and only the upper 768 bytes of each 1KB block
  assign pri_isa_alias = isa_en_i &&
                         (pri_addr_i[31:16] == `BIOWD_ISA_HI_ZERO) &&
                         (pri_addr_i[9:8] != `BIOWD_ISA_LOW_QTR);
  assign sec_isa_alias = isa_en_i &&
                         (sec_addr_i[31:16] == `BIOWD_ISA_HI_ZERO) &&
                         (sec_addr_i[9:8] != `BIOWD_ISA_LOW_QTR);

  // ----------------------------------------------------------------------
  // Forwarding decision
  // ----------------------------------------------------------------------
  reg nxt_down;
  reg nxt_up;
  reg nxt_prefetch;
  reg nxt_single;

  // Address translation is never applied; decisions are pure membership
  always @* begin
    nxt_down = 1'b0;
    nxt_up = 1'b0;
    nxt_prefetch = 1'b0;
    nxt_single = 1'b0;
    if (pri_valid_i) begin
      if (pri_is_io) begin
        // ISA alias withheld from downstream even inside the window
        nxt_down = io_en_i && pri_io_hit && !pri_isa_alias;
      end else if (pri_is_mem) begin
        nxt_down = mem_en_i && pri_mm_hit;
        if (nxt_down) begin
          // Side effects possible here, so plain reads stop after one
          nxt_prefetch = (pri_cmd_i == `BIOWD_CMD_MEM_RD_MUL) ||
                         (pri_cmd_i == `BIOWD_CMD_MEM_RD_LINE);
          nxt_single = (pri_cmd_i == `BIOWD_CMD_MEM_RD);
        end
      end
    end
    if (sec_valid_i && master_en_i) begin
      if (sec_is_io) begin
        // Gap-free complement of the downstream set
        nxt_up = !sec_io_hit || sec_isa_alias;
      end else if (sec_is_mem) begin
        nxt_up = !sec_mm_hit && !sec_mem_other_claim_i;
      end
    end
  end

  // Decisions are registered so every output leaves a flip-flop
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pri_fwd_down_o <= 1'b0;
      sec_fwd_up_o <= 1'b0;
      fwd_prefetch_o <= 1'b0;
      fwd_single_o <= 1'b0;
      dec_valid_o <= 1'b0;
    end else begin
      pri_fwd_down_o <= nxt_down;
      sec_fwd_up_o <= nxt_up;
      fwd_prefetch_o <= nxt_prefetch;
      fwd_single_o <= nxt_single;
      dec_valid_o <= pri_valid_i || sec_valid_i;
    end
  end
endmodule // biowd_decoder

//--- pkg/biowd_map.vh
// Register map, reset values and decode constants for the window decoder.
//
// Overview of operation
// - Primary-side I/O is never claimed while the I/O enable bit is clear.
// - Master enable clear ignores all secondary-side I/O and memory traffic.
// - I/O inside the window goes downstream; outside goes upstream.
// - Base above limit disables the I/O window; all secondary I/O goes up.
// - I/O window decodes full 32-bit addresses with 4KB granularity.
// - Low base byte holds bits 15:12 high, reads 1h low; bits 11:0 zero.
// - Upper 16-bit base register is read/write; base resets to zero.
// - Limit mirrors base layout; limit bits 11:0 are FFFh; resets 0000 0FFFh.
// - ISA mode only affects in-window addresses with bits 31:16 zero.
// - ISA mode forwards downstream only the low 256 bytes of each 1KB below 64KB.
// - ISA mode sends upper 768 bytes per 1KB below 64KB upstream.
// - Otherwise secondary I/O goes upstream only when outside the window.
// - Memory goes downstream only while memory enable is set.
// - Primary memory in MMIO window goes downstream; secondary is ignored.
// - Outside MMIO window: primary ignored; secondary up unless claimed.
// - MMIO prefetch only on read line or read multiple; plain read one phase.
// - MMIO base and limit hold bits 31:20 in top 12 bits; low 4 zero.
// - MMIO window is 32-bit, 1MB granular; limit low bits are F FFFFh.
// - MMIO base resets to zero and limit to 000F FFFFh.
// - MMIO base above limit disables the MMIO window.
// - No translation; anything not sent downstream is sent upstream unless another decoder claims it.
`ifndef BIOWD_MAP_VH
`define BIOWD_MAP_VH

// ----------------------------------------------------------------------
// Configuration offsets (byte addresses)
// ----------------------------------------------------------------------
`define BIOWD_OFS_IO_BASE_LO 8'h1c
`define BIOWD_OFS_IO_LIMIT_LO 8'h1d
`define BIOWD_OFS_MMIO_BASE 8'h20
`define BIOWD_OFS_MMIO_LIMIT 8'h22
`define BIOWD_OFS_IO_BASE_HI 8'h30
`define BIOWD_OFS_IO_LIMIT_HI 8'h32

// ----------------------------------------------------------------------
// Fixed fields and reset values
// ----------------------------------------------------------------------
`define BIOWD_IO_CAP_32 4'h1
`define BIOWD_IO_BASE_MID_RST 4'h0
`define BIOWD_IO_BASE_HI_RST 16'h0000
`define BIOWD_IO_LIMIT_MID_RST 4'h0
`define BIOWD_IO_LIMIT_HI_RST 16'h0000
`define BIOWD_IO_BASE_FILL 12'h000
`define BIOWD_IO_LIMIT_FILL 12'hfff
`define BIOWD_MMIO_LOW_ZERO 4'h0
`define BIOWD_MMIO_BASE_RST 12'h000
`define BIOWD_MMIO_LIMIT_RST 12'h000
`define BIOWD_MMIO_BASE_FILL 20'h00000
`define BIOWD_MMIO_LIMIT_FILL 20'hfffff
`define BIOWD_ISA_HI_ZERO 16'h0000
`define BIOWD_ISA_LOW_QTR 2'b00

// ----------------------------------------------------------------------
// Bus command codes
// ----------------------------------------------------------------------
`define BIOWD_CMD_IO_RD 4'h2
`define BIOWD_CMD_IO_WR 4'h3
`define BIOWD_CMD_MEM_RD 4'h6
`define BIOWD_CMD_MEM_WR 4'h7
`define BIOWD_CMD_MEM_RD_MUL 4'hc
`define BIOWD_CMD_MEM_RD_LINE 4'he
`define BIOWD_CMD_MEM_WR_INV 4'hf

`endif

//--- hw/biowd_range_cmp.v
// Inclusive range comparator for one address window.
`timescale 1ns/1ps
module biowd_range_cmp #(
  parameter W = 32
) (
  input wire [W-1:0] addr_i,
  input wire [W-1:0] base_i,
  input wire [W-1:0] limit_i,
  output wire hit_o
);
  // ----------------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------------
  // Base above limit yields no hit, so the window is off
  assign hit_o = (addr_i >= base_i) && (addr_i <= limit_i);
endmodule // biowd_range_cmp

//--- test/biowd_decoder_sva.sv
// Port checker for the I/O and memory-mapped window decoder.
`timescale 1ns/1ps
module biowd_decoder_sva (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cfg_rd_i,
  input wire logic cfg_rvalid_o,
  input wire logic io_en_i,
  input wire logic mem_en_i,
  input wire logic master_en_i,
  input wire logic isa_en_i,
  input wire logic sec_mem_other_claim_i,
  input wire logic pri_valid_i,
  input wire logic [3:0] pri_cmd_i,
  input wire logic [31:0] pri_addr_i,
  input wire logic sec_valid_i,
  input wire logic [3:0] sec_cmd_i,
  input wire logic [31:0] sec_addr_i,
  input wire logic pri_fwd_down_o,
  input wire logic sec_fwd_up_o,
  input wire logic fwd_prefetch_o,
  input wire logic fwd_single_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // --------------------------------------------------------------
  // Command classes and low-64KB alias hits
  // --------------------------------------------------------------
  wire pio = pri_valid_i && pri_cmd_i[3:1] == 3'h1;
  wire sio = sec_valid_i && sec_cmd_i[3:1] == 3'h1;
  wire pmem = pri_valid_i && (pri_cmd_i[3:1] == 3'h3 ||
    pri_cmd_i == 4'hc || pri_cmd_i[3:1] == 3'h7);
  wire smem = sec_valid_i && (sec_cmd_i[3:1] == 3'h3 ||
    sec_cmd_i == 4'hc || sec_cmd_i[3:1] == 3'h7);
  wire al_p = isa_en_i && pri_addr_i[31:16] == 16'h0 &&
    pri_addr_i[9:8] != 2'h0;
  wire al_s = isa_en_i && sec_addr_i[31:16] == 16'h0 &&
    sec_addr_i[9:8] != 2'h0;
  // Plain read that the window accepted must stay one data phase
  sequence s_single_req;
    pri_valid_i && pri_cmd_i == 4'h6 && mem_en_i ##1 pri_fwd_down_o;
  endsequence
  sequence s_rd_ans;
    cfg_rd_i ##1 cfg_rvalid_o;
  endsequence
  property p_io_off;
    pio && !io_en_i |=> !pri_fwd_down_o;
  endproperty
  property p_master_off;
    !master_en_i |=> !sec_fwd_up_o;
  endproperty
  property p_mem_off;
    pmem && !mem_en_i |=> !pri_fwd_down_o;
  endproperty
  property p_isa_down;
    pio && al_p |=> !pri_fwd_down_o;
  endproperty
  property p_isa_up;
    sio && al_s && master_en_i |=> sec_fwd_up_o;
  endproperty
  property p_claim;
    smem && sec_mem_other_claim_i |=> !sec_fwd_up_o;
  endproperty
  property p_prefetch;
    fwd_prefetch_o |-> pri_fwd_down_o &&
      ($past(pri_cmd_i) == 4'hc || $past(pri_cmd_i) == 4'he);
  endproperty
  property p_single;
    s_single_req |-> fwd_single_o && !fwd_prefetch_o;
  endproperty
  property p_rd;
    cfg_rd_i |-> s_rd_ans;
  endproperty
  a_io_off: assert property (p_io_off) else $error("io claimed");
  a_master_off: assert property (p_master_off) else $error("up");
  a_mem_off: assert property (p_mem_off) else $error("mem down");
  a_isa_down: assert property (p_isa_down) else $error("alias");
  a_isa_up: assert property (p_isa_up) else $error("no alias up");
  a_claim: assert property (p_claim) else $error("claimed up");
  a_prefetch: assert property (p_prefetch) else $error("pf");
  a_single: assert property (p_single) else $error("single");
  a_rd: assert property (p_rd) else $error("no read answer");
endmodule // biowd_decoder_sva

//--- test/biowd_initiator.sv
// Address-phase initiator model for one side of the bridge.
`timescale 1ns/1ps
module biowd_initiator (
  output reg valid_o,
  output reg [3:0] cmd_o,
  output reg [31:0] addr_o
);
  // Released lines flip rather than hold a stale copy
  initial begin
    valid_o = 1'b0;
    cmd_o = 4'h0;
    addr_o = 32'h0;
  end
  task put(input v, input [3:0] c, input [31:0] a);
    begin
      valid_o = v;
      cmd_o = v ? c : ~cmd_o;
      addr_o = v ? a : ~addr_o;
    end
  endtask
endmodule // biowd_initiator

//--- test/biowd_decoder_bench.sv
// Self-checking bench for the window decoder.
`timescale 1ns/1ps
module biowd_decoder_bench;
  reg clk_i, arst_n_i, cfg_wr_i, cfg_rd_i;
  reg [7:0] cfg_addr_i;
  reg [1:0] cfg_be_i;
  reg [15:0] cfg_wdata_i, d;
  reg io_en_i, mem_en_i, master_en_i, isa_en_i, claim;
  reg [3:0] mc [0:4];
  wire pv, sv, cv, down, up, pf, sg, dv;
  wire [3:0] pc, sc;
  wire [31:0] pa, sa;
  wire [15:0] rdata;
  integer failures, checks, i;
  biowd_initiator p_pri (.valid_o(pv), .cmd_o(pc), .addr_o(pa));
  biowd_initiator p_sec (.valid_o(sv), .cmd_o(sc), .addr_o(sa));
  biowd_decoder i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
    .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(rdata), .cfg_rvalid_o(cv), .io_en_i(io_en_i),
    .mem_en_i(mem_en_i), .master_en_i(master_en_i),
    .isa_en_i(isa_en_i), .sec_mem_other_claim_i(claim),
    .pri_valid_i(pv), .pri_cmd_i(pc), .pri_addr_i(pa),
    .sec_valid_i(sv), .sec_cmd_i(sc), .sec_addr_i(sa),
    .pri_fwd_down_o(down), .sec_fwd_up_o(up), .fwd_prefetch_o(pf),
    .fwd_single_o(sg), .dec_valid_o(dv));
  // --------------------------------------------------------------
  // Clock, reset and bus tasks
  // --------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: %h vs %h", $time, seen, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task do_reset;
    begin
      arst_n_i = 1'b0;
      repeat (10) @(negedge clk_i);
      arst_n_i = 1'b1;
      @(negedge clk_i);
    end
  endtask
  // Strobes drop for a full cycle so calls never collide
  task wr(input [7:0] a, input [15:0] v);
    begin
      cfg_wr_i = 1'b1;
      cfg_addr_i = a;
      cfg_wdata_i = v;
      @(negedge clk_i);
      cfg_wr_i = 1'b0;
      @(negedge clk_i);
    end
  endtask
  task rd(input [7:0] a);
    begin
      cfg_rd_i = 1'b1;
      cfg_addr_i = a;
      @(negedge clk_i);
      d = rdata;
      check(cv, 32'h1);
      cfg_rd_i = 1'b0;
      @(negedge clk_i);
    end
  endtask
  task dec(input [3:0] c0, input [31:0] a0, input [3:0] c1,
    input [31:0] a1, input [3:0] e);
    begin
      p_pri.put(1'b1, c0, a0);
      p_sec.put(1'b1, c1, a1);
      @(negedge clk_i);
      check({dv, down, up, pf, sg}, {1'b1, e});
      // Idle cycle so later config changes meet quiet buses
      p_pri.put(1'b0, 4'h0, 32'h0);
      p_sec.put(1'b0, 4'h0, 32'h0);
      @(negedge clk_i);
    end
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    {cfg_wr_i, cfg_rd_i, io_en_i, mem_en_i, master_en_i} = 5'h0;
    {isa_en_i, claim, cfg_addr_i, cfg_wdata_i} = 26'h0;
    cfg_be_i = 2'h3;
    failures = 0;
    checks = 0;
    {mc[0], mc[1], mc[2], mc[3], mc[4]} = 20'h67cef;
    do_reset;
    rd(8'h1c); check(d, 16'h0101);
    rd(8'h20); check(d, 16'h0000);
    rd(8'h40); check(d, 16'h0000);
    wr(8'h30, 16'h0001); wr(8'h32, 16'h0001); wr(8'h1c, 16'h201f);
    rd(8'h1c); check(d, 16'h2111);
    rd(8'h32); check(d, 16'h0001);
    io_en_i = 1'b1;
    master_en_i = 1'b1;
    dec(4'h2, 32'h00011000, 4'h3, 32'h00010fff, 4'hc);
    dec(4'h3, 32'h00012fff, 4'h2, 32'h00013000, 4'hc);
    dec(4'h2, 32'h00010fff, 4'h3, 32'h00012000, 4'h0);
    dec(4'ha, 32'h00011800, 4'ha, 32'h00013000, 4'h0);
    io_en_i = 1'b0;
    dec(4'h2, 32'h00011800, 4'h3, 32'h0, 4'h4);
    io_en_i = 1'b1;
    master_en_i = 1'b0;
    dec(4'h2, 32'h00011800, 4'h7, 32'h80000000, 4'h8);
    master_en_i = 1'b1;
    wr(8'h30, 16'h0); wr(8'h1c, 16'hf000);
    isa_en_i = 1'b1;
    dec(4'h2, 32'h100, 4'h3, 32'h100, 4'h4);
    dec(4'h2, 32'h4ff, 4'h3, 32'h400, 4'h8);
    dec(4'h3, 32'hfe00, 4'h2, 32'hff00, 4'h4);
    dec(4'h2, 32'h10300, 4'h3, 32'h10300, 4'h8);
    isa_en_i = 1'b0;
    dec(4'h2, 32'h300, 4'h3, 32'h300, 4'h8);
    wr(8'h32, 16'h0); wr(8'h1c, 16'h0010);
    dec(4'h2, 32'hfff, 4'h3, 32'h1000, 4'h4);
    mem_en_i = 1'b1;
    dec(4'h6, 32'h000fffff, 4'h7, 32'h00100000, 4'hd);
    wr(8'h20, 16'h001f); wr(8'h22, 16'h002f);
    rd(8'h22); check(d, 16'h0020);
    for (i = 0; i < 5; i = i + 1) begin
      dec(mc[i], 32'h00100000, mc[i], 32'h002fffff, {2'h2,
        mc[i] == 4'hc || mc[i] == 4'he, mc[i] == 4'h6});
    end
    dec(4'hc, 32'h000fffff, 4'h6, 32'h00300000, 4'h4);
    claim = 1'b1;
    dec(4'he, 32'h002fffff, 4'h7, 32'h00300000, 4'ha);
    claim = 1'b0;
    mem_en_i = 1'b0;
    dec(4'h7, 32'h00100000, 4'hb, 32'h0, 4'h0);
    mem_en_i = 1'b1;
    wr(8'h20, 16'h0030);
    dec(4'h6, 32'h00300000, 4'h6, 32'h00100000, 4'h4);
    p_pri.put(1'b0, 4'h0, 32'h0);
    p_sec.put(1'b0, 4'h0, 32'h0);
    // Single-lane writes: only the enabled byte may change
    cfg_be_i = 2'h1;
    wr(8'h1d, 16'hff30);
    wr(8'h30, 16'hab12);
    cfg_be_i = 2'h3;
    rd(8'h1d);
    check(d, 16'h0031);
    rd(8'h30);
    check(d, 16'h0012);
    do_reset;
    rd(8'h20); check(d, 16'h0000);
    rd(8'h30); check(d, 16'h0000);
    rd(8'h1d);
    check(d, 16'h0001);
    finish_test;
  end
  // Hang guard well beyond the roughly 110 cycles used
  initial begin
    #20000;
    failures = failures + 1;
    finish_test;
  end
endmodule // biowd_decoder_bench
bind biowd_decoder biowd_decoder_sva i_sva (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .cfg_rd_i(cfg_rd_i), .cfg_rvalid_o(cfg_rvalid_o),
  .io_en_i(io_en_i), .mem_en_i(mem_en_i), .master_en_i(master_en_i),
  .isa_en_i(isa_en_i), .sec_mem_other_claim_i(sec_mem_other_claim_i),
  .pri_valid_i(pri_valid_i), .pri_cmd_i(pri_cmd_i),
  .pri_addr_i(pri_addr_i), .sec_valid_i(sec_valid_i),
  .sec_cmd_i(sec_cmd_i), .sec_addr_i(sec_addr_i),
  .pri_fwd_down_o(pri_fwd_down_o), .sec_fwd_up_o(sec_fwd_up_o),
  .fwd_prefetch_o(fwd_prefetch_o), .fwd_single_o(fwd_single_o));
